/* rtl/tm_timer_io.sv */
// Register access over Wishbone was decided locally.
`timescale 1ns/100ps
// Operation
// (R01) Software makes port-5 line 6 an output before using the timer output.
// (R02) Mode bits 7:6: 10 routes toggle output, 00 returns line to port data.
// (R03) Mode bits 7:6 both set drive the internal clock, crystal/2, onto the pin.
// (R04) Setting the load bit forces the output toggle flip-flop high.
// (R05) Each end-of-count inverts the toggle flip-flop driving the output pin.
// (R06) Continuous counting with fixed initial values gives a half-duty square wave.
// (R07) Port writes leave the timer output line alone; reads return its driven level.
// (R08) Software clears the clock-source bit to select the external input.
// (R09) Mode bits 5:4 pick external clock, gated, triggered or retriggerable input.
// (R10) Input counting needs enable; trigger modes load initial values automatically.
// (R11) Software makes port-5 line 2 an input before using it as timer input.
// (R12) Every falling input edge raises the edge request, whatever the mode.
// (R13) In external clock mode each falling input edge clocks the prescaler.
// (R14) In gated mode the timer clock drives the prescaler only while input is high.
// (R15) Triggered mode loads and starts on first falling edge; later edges ignored.
// (R16) Triggered single-pass end-of-count clears enable; continuous runs until cleared.
// (R17) Retriggerable mode reloads and restarts on every falling edge while enabled.
// (R18) Retriggerable single-pass end-of-count clears enable; edges then ignored.
// (R19) Retriggerable end-of-count fires only a full interval after the last edge.
// (R20) Load bit copies initial values into down-counters and self-clears next clock.
// (R21) The timer input passes a two-stage synchroniser before edge or level use.
module tm_timer_io #(
    parameter int XTAL_PER_TCLK = tm_pkg::TM_XTAL_PER_TCLK
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire tm_pkg::tm_wb_req_s wb_req,
    output logic [tm_pkg::TM_DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] port5_in,
    output logic [7:0] port5_out,
    output logic [7:0] port5_oe,
    output logic counter_done_request,
    output logic input_edge_request
);
    import tm_pkg::*;

    localparam int DIV_W = $clog2(XTAL_PER_TCLK);

    logic ack_r;
    logic [TM_DAT_W-1:0] rdat_r;
    logic [7:0] mode_r;
    logic [7:0] scaler_r;
    logic [7:0] init_r;
    logic [7:0] p5_data_r;
    logic [7:0] p5_dir_r;
    logic [DIV_W-1:0] div_r;
    logic [5:0] pre_r;
    logic [5:0] pre_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic rest_r;
    logic toggle_r;
    logic [7:0] pin_out_r;
    logic [7:0] pin_out_nxt;
    logic done_r;
    logic edge_r;
    tm_st_e st_r;
    tm_st_e st_nxt;
    logic tin_level;
    logic tin_fall;
    logic access;
    logic wr_fire;
    logic [7:0] idx;
    logic wr_mode;
    logic load_go;
    logic trig_load;
    logic tclk;
    logic iclk_rise;
    logic tick;
    logic pre_carry;
    logic eoc;
    logic single;
    logic trig_mode;
    logic [1:0] out_sel;
    tm_in_e in_mode;

    // The timer clock must be a power of two of crystal cycles so the divider wraps.
    if (XTAL_PER_TCLK < 2 || (XTAL_PER_TCLK & (XTAL_PER_TCLK - 1)) != 0) begin
        $error("XTAL_PER_TCLK must be a power of two of at least two");
    end

    tm_pin_sync #(
        .STAGES(TM_SYNC_STAGES)
    ) u_tin_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin_async(port5_in[TM_LINE_IN]), // R21
        .pin_level(tin_level),
        .pin_fall(tin_fall)
    );

    // Bus decode. A write takes effect on the edge at which ack is seen high.
    assign access = wb_req.cyc & wb_req.stb;
    assign wr_fire = access & wb_req.we & ack_r & wb_req.sel[0];
    assign idx = tm_index(wb_req.adr);
    assign wr_mode = wr_fire && (idx == TM_IDX_MODE);
    assign load_go = wr_mode & wb_req.dat[TM_MODE_LOAD];

    // Field views.
    assign out_sel = mode_r[TM_MODE_OUT_HI:TM_MODE_OUT_LO];
    assign in_mode = tm_in_e'(mode_r[TM_MODE_IN_HI:TM_MODE_IN_LO]);
    assign single = ~scaler_r[TM_SCL_CONT];
    assign trig_mode = ~scaler_r[TM_SCL_SRC] &&
        (in_mode == TM_IN_TRIG || in_mode == TM_IN_RETRIG); // R09

    // Ack one cycle after the request, dropped in the cycle after it was given.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= access & ~ack_r;
        end
    end

    // Read data is captured while ack is being raised. Unmapped indices read zero.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdat_r <= '0;
        end else if (access && !ack_r && !wb_req.we) begin
            case (idx)
                TM_IDX_MODE: rdat_r <= {24'h000000, mode_r};
                TM_IDX_COUNT: rdat_r <= {24'h000000, cnt_r};
                TM_IDX_SCALER: rdat_r <= {24'h000000, scaler_r};
                TM_IDX_P5_DIR: rdat_r <= {24'h000000, p5_dir_r};
                TM_IDX_P5_DATA: begin
                    // Outputs read their driven level, the timer line included.
                    rdat_r <= {24'h000000, (port5_in & p5_dir_r) | (pin_out_r & ~p5_dir_r)}; // R07
                end
                default: rdat_r <= '0;
            endcase
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // Crystal divider: bit 0 is the internal clock, the wrap is the timer clock.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    assign iclk_rise = div_r[0];
    assign tclk = &div_r;

    // Mode register. Load self-clears on the next internal clock; a single-pass
    // end-of-count in a trigger mode drops enable unless software writes at once.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_r <= TM_MODE_RST;
        end else if (wr_mode) begin
            mode_r <= wb_req.dat[7:0];
        end else begin
            if (iclk_rise) begin
                mode_r[TM_MODE_LOAD] <= 1'b0; // R20
            end
            if (eoc && single && trig_mode) begin
                mode_r[TM_MODE_EN] <= 1'b0; // R16 R18
            end
        end
    end

    // Scaler, initial count and port direction registers.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            scaler_r <= TM_SCALER_RST;
            init_r <= TM_COUNT_RST;
            p5_dir_r <= TM_P5_DIR_RST;
        end else if (wr_fire) begin
            if (idx == TM_IDX_SCALER) begin
                scaler_r <= wb_req.dat[7:0];
            end
            if (idx == TM_IDX_COUNT) begin
                init_r <= wb_req.dat[7:0];
            end
            if (idx == TM_IDX_P5_DIR) begin
                p5_dir_r <= wb_req.dat[7:0];
            end
        end
    end

    // Port data latch; line 6 keeps its value while it serves the timer.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            p5_data_r <= TM_P5_DATA_RST;
        end else if (wr_fire && idx == TM_IDX_P5_DATA) begin
            p5_data_r <= wb_req.dat[7:0];
            if (out_sel != TM_OUT_PORT) begin
                p5_data_r[TM_LINE_OUT] <= p5_data_r[TM_LINE_OUT]; // R07
            end
        end
    end

    // Run state. Trigger modes wait for a falling edge before counting.
    always_comb begin
        st_nxt = st_r;
        trig_load = 1'b0;
        case (st_r)
            TM_ST_IDLE: begin
                if (mode_r[TM_MODE_EN]) begin
                    st_nxt = trig_mode ? TM_ST_WAIT : TM_ST_RUN;
                end
            end
            TM_ST_WAIT: begin
                if (!trig_mode) begin
                    st_nxt = TM_ST_RUN;
                end else if (tin_fall) begin
                    st_nxt = TM_ST_RUN; // R15
                    trig_load = 1'b1; // R10
                end
            end
            TM_ST_RUN: begin
                // Triggered mode ignores later edges; retrigger restarts.
                if (trig_mode && in_mode == TM_IN_RETRIG && tin_fall) begin
                    trig_load = 1'b1; // R17
                end
            end
            default: st_nxt = TM_ST_IDLE;
        endcase
        if (!mode_r[TM_MODE_EN]) begin
            st_nxt = TM_ST_IDLE; // R18
            trig_load = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= TM_ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Clock source to the prescaler. Internal source uses the timer clock alone.
    always_comb begin
        if (scaler_r[TM_SCL_SRC]) begin
            tick = tclk;
        end else begin
            case (in_mode)
                TM_IN_EXT: tick = tin_fall; // R13
                TM_IN_GATE: tick = tclk & tin_level; // R14
                default: tick = tclk;
            endcase
        end
        tick = tick && (st_r == TM_ST_RUN) && !trig_load; // R10
    end

    // Prescaler counts its modulo down to one; zero in the field means 64.
    assign pre_carry = tick && (pre_r == 6'h01);
    assign eoc = pre_carry && !rest_r && (cnt_r == 8'h01);

    always_comb begin
        pre_nxt = pre_r;
        if (load_go || trig_load) begin
            pre_nxt = scaler_r[TM_SCL_MOD_HI:TM_SCL_MOD_LO]; // R20
        end else if (pre_carry) begin
            pre_nxt = scaler_r[TM_SCL_MOD_HI:TM_SCL_MOD_LO];
        end else if (tick) begin
            pre_nxt = pre_r - 6'h01;
        end
    end

    // Main down-counter. A start value of 00h counts 256 carries.
    always_comb begin
        cnt_nxt = cnt_r;
        if (load_go || trig_load) begin
            cnt_nxt = init_r; // R20
        end else if (eoc) begin
            // Continuous reloads the initial value; single-pass rests at 00h.
            cnt_nxt = single ? 8'h00 : init_r; // R06
        end else if (pre_carry && !rest_r) begin
            cnt_nxt = cnt_r - 8'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_r <= 6'h00;
            cnt_r <= TM_COUNT_RST;
        end else begin
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Rest flag for single-pass; outside trigger modes the prescaler keeps running meanwhile.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rest_r <= 1'b0;
        end else if (load_go || trig_load) begin
            rest_r <= 1'b0;
        end else if (eoc && single) begin
            rest_r <= 1'b1;
        end
    end

    // Output toggle flip-flop. Load wins because it re-initialises the waveform.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            toggle_r <= 1'b1;
        end else if (load_go) begin
            toggle_r <= 1'b1; // R04
        end else if (eoc) begin
            toggle_r <= ~toggle_r; // R05 R19
        end
    end

    // Request pulses, one cycle each.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            done_r <= 1'b0;
            edge_r <= 1'b0;
        end else begin
            done_r <= eoc; // R19
            edge_r <= tin_fall; // R12
        end
    end

    assign counter_done_request = done_r;
    assign input_edge_request = edge_r;

    // Pin output selection, registered so the pins come straight from flops.
    always_comb begin
        pin_out_nxt = p5_data_r;
        case (out_sel)
            TM_OUT_TOGGLE: pin_out_nxt[TM_LINE_OUT] = toggle_r; // R02
            TM_OUT_ICLK: pin_out_nxt[TM_LINE_OUT] = ~div_r[0]; // R03
            default: pin_out_nxt[TM_LINE_OUT] = p5_data_r[TM_LINE_OUT]; // R02
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_out_r <= TM_P5_DATA_RST;
        end else begin
            pin_out_r <= pin_out_nxt;
        end
    end

    // A direction bit of zero makes the line an output.
    assign port5_out = pin_out_r;
    assign port5_oe = ~p5_dir_r; // R01 R11

endmodule

/* include/tm_pkg.sv */
package tm_pkg;

    // Bus geometry. Registers are 8 bits wide in the low byte of an aligned word.
    localparam int TM_ADR_W = 10;
    localparam int TM_DAT_W = 32;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] TM_IDX_P5_DATA = 8'h05;
    localparam logic [7:0] TM_IDX_P5_DIR = 8'h14;
    localparam logic [7:0] TM_IDX_MODE = 8'hF1;
    localparam logic [7:0] TM_IDX_COUNT = 8'hF2;
    localparam logic [7:0] TM_IDX_SCALER = 8'hF3;

    // Fields of timer_mode_control.
    localparam int TM_MODE_OUT_HI = 7;
    localparam int TM_MODE_OUT_LO = 6;
    localparam int TM_MODE_IN_HI = 5;
    localparam int TM_MODE_IN_LO = 4;
    localparam int TM_MODE_EN = 3;
    localparam int TM_MODE_LOAD = 2;

    // Fields of timer_scaler_config.
    localparam int TM_SCL_MOD_HI = 7;
    localparam int TM_SCL_MOD_LO = 2;
    localparam int TM_SCL_SRC = 1;
    localparam int TM_SCL_CONT = 0;

    // Port-5 lines used by the timer.
    localparam int TM_LINE_OUT = 6;
    localparam int TM_LINE_IN = 2;

    // Output selections of the mode register.
    localparam logic [1:0] TM_OUT_PORT = 2'h0;
    localparam logic [1:0] TM_OUT_TOGGLE = 2'h2;
    localparam logic [1:0] TM_OUT_ICLK = 2'h3;

    // Reset values.
    localparam logic [7:0] TM_MODE_RST = 8'h00;
    localparam logic [7:0] TM_SCALER_RST = 8'h00;
    localparam logic [7:0] TM_COUNT_RST = 8'h00;
    localparam logic [7:0] TM_P5_DATA_RST = 8'h00;
    localparam logic [7:0] TM_P5_DIR_RST = 8'hFF;

    // Timing: sys_clk is the crystal; internal clock is crystal/2, timer clock internal/4.
    localparam int TM_SYS_CLK_MHZ = 125;
    localparam int TM_ICLK_DIV = 2;
    localparam int TM_TCLK_PER_ICLK = 4;
    localparam int TM_XTAL_PER_TCLK = TM_ICLK_DIV * TM_TCLK_PER_ICLK;
    localparam int TM_SYNC_STAGES = 2;

    // Input functions of the timer input line.
    typedef enum logic [1:0] {
        TM_IN_EXT = 2'h0,
        TM_IN_GATE = 2'h1,
        TM_IN_TRIG = 2'h2,
        TM_IN_RETRIG = 2'h3
    } tm_in_e;

    // Run state of the counter; Gray along idle, wait, run.
    typedef enum logic [1:0] {
        TM_ST_IDLE = 2'h0,
        TM_ST_WAIT = 2'h1,
        TM_ST_RUN = 2'h3
    } tm_st_e;

    // Classic Wishbone request from the master.
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [TM_ADR_W-1:0] adr;
        logic [TM_DAT_W-1:0] dat;
    } tm_wb_req_s;

    // Register index from a byte address.
    function automatic logic [7:0] tm_index(input logic [TM_ADR_W-1:0] adr);
        return adr[TM_ADR_W-1:2];
    endfunction

endpackage

/* rtl/tm_pin_sync.sv */
`timescale 1ns/100ps
// Brings the asynchronous timer input into the sys_clk domain and finds falling edges.
module tm_pin_sync #(
    parameter int STAGES = tm_pkg::TM_SYNC_STAGES
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic pin_async,
    output logic pin_level,
    output logic pin_fall
);
    import tm_pkg::*;

    logic [STAGES-1:0] sync_r;
    logic last_r;

    // Fewer than two stages would leave metastability on the edge detector.
    if (STAGES < 2) begin
        $error("tm_pin_sync needs at least two stages");
    end

    // Shift chain; only the last stage is looked at by any logic.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_r <= '1;
        end else begin
            sync_r <= {sync_r[STAGES-2:0], pin_async}; // R21
        end
    end

    // Delayed copy of the clean level for edge detection.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            last_r <= 1'b1;
        end else begin
            last_r <= sync_r[STAGES-1];
        end
    end

    assign pin_level = sync_r[STAGES-1];
    assign pin_fall = last_r & ~sync_r[STAGES-1];

endmodule

/* verif/tm_timer_io_asserts.sv */
`timescale 1ns/100ps
// Port-level checks of the timer block. Register shadows follow committed
// writes, so pin behaviour is judged without looking inside.
module tm_timer_io_asserts (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire tm_pkg::tm_wb_req_s wb_req,
    input wire logic [tm_pkg::TM_DAT_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [7:0] port5_in,
    input wire logic [7:0] port5_out,
    input wire logic [7:0] port5_oe,
    input wire logic counter_done_request,
    input wire logic input_edge_request
);
    import tm_pkg::*;
    logic wr_hit;
    logic [7:0] idx;
    logic [7:0] mode_r;
    logic [7:0] data_r;
    logic [7:0] dir_r;
    logic [2:0] quiet_r;

    // A write commits at the edge where ack is sampled high.
    assign wr_hit = wb_ack_o && wb_req.cyc && wb_req.stb && wb_req.we && wb_req.sel[0];
    assign idx = wb_req.adr[TM_ADR_W-1:2];

    // Shadows of the registers that steer the port lines.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_r <= TM_MODE_RST;
            data_r <= TM_P5_DATA_RST;
            dir_r <= TM_P5_DIR_RST;
        end else if (wr_hit) begin
            if (idx == TM_IDX_MODE) mode_r <= wb_req.dat[7:0];
            if (idx == TM_IDX_P5_DATA) data_r <= wb_req.dat[7:0];
            if (idx == TM_IDX_P5_DIR) dir_r <= wb_req.dat[7:0];
        end
    end

    // Cycles since the last write or end-of-count. Pin checks wait for it,
    // trading a few unchecked cycles for freedom in the output latency.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) quiet_r <= 3'h0;
        else if (wr_hit || counter_done_request) quiet_r <= 3'h0;
        else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    a_ack_follows: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_read_upper: assert property (wb_ack_o && !wb_req.we |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_edge_seen: assert property (
        $fell(port5_in[TM_LINE_IN]) |-> ##[3:5] input_edge_request)
        else $error("falling input edge not reported");
    a_edge_pulse: assert property (input_edge_request |=> !input_edge_request)
        else $error("edge request longer than one cycle");
    a_done_pulse: assert property (counter_done_request |=> !counter_done_request)
        else $error("done request longer than one cycle");
    a_toggle_done: assert property (
        mode_r[7:6] == TM_OUT_TOGGLE && counter_done_request
        |-> ##[0:2] port5_out[TM_LINE_OUT] != $past(port5_out[TM_LINE_OUT]))
        else $error("output did not toggle at end-of-count");
    a_toggle_hold: assert property (
        mode_r[7:6] == TM_OUT_TOGGLE && quiet_r >= 3'h4 |-> $stable(port5_out[TM_LINE_OUT]))
        else $error("timer output moved without end-of-count");
    a_port_data: assert property (
        mode_r[7:6] == TM_OUT_PORT && quiet_r >= 3'h4
        |-> port5_out[TM_LINE_OUT] == data_r[TM_LINE_OUT])
        else $error("line does not follow port data");
    a_iclk_out: assert property (
        mode_r[7:6] == TM_OUT_ICLK && quiet_r >= 3'h4
        |-> port5_out[TM_LINE_OUT] != $past(port5_out[TM_LINE_OUT]))
        else $error("internal clock not on output line");
    a_dir_oe: assert property (quiet_r >= 3'h4 |-> port5_oe == ~dir_r)
        else $error("enables do not follow direction");
endmodule

bind tm_timer_io tm_timer_io_asserts tm_timer_io_asserts_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .port5_in(port5_in), .port5_out(port5_out),
    .port5_oe(port5_oe), .counter_done_request(counter_done_request),
    .input_edge_request(input_edge_request)
);

/* verif/tm_pin_model.sv */
`timescale 1ns/100ps
// Far side of port 5: an event source on the timer input line and pull-ups
// on the rest. A line the block drives reads back its driven level.
module tm_pin_model (
    input wire logic [7:0] port5_out,
    input wire logic [7:0] port5_oe,
    input wire logic event_level,
    output logic [7:0] port5_in
);
    import tm_pkg::*;

    // Released lines other than the timer input go to the pull-up, so no stale value lingers.
    always_comb begin
        for (int j = 0; j < 8; j++) begin
            if (port5_oe[j]) port5_in[j] = port5_out[j];
            else if (j == TM_LINE_IN) port5_in[j] = event_level;
            else port5_in[j] = 1'b1;
        end
    end
endmodule

/* verif/tb.sv */
`timescale 1ns/100ps
// Bench for the timer block: register traffic over Wishbone and events on
// the timer input line; every scenario judges its own results.
module tb;
    import tm_pkg::*;
    localparam int TK = TM_XTAL_PER_TCLK;
    logic sys_clk;
    logic rst_b;
    logic ev;
    logic ack;
    logic done;
    logic in_edge;
    logic [7:0] p_in;
    logic [7:0] p_out;
    logic [7:0] p_oe;
    logic [7:0] r;
    logic [TM_DAT_W-1:0] rdat;
    tm_wb_req_s req;
    int bad_count;
    int total_checks;
    int n_done;
    int n_edge;
    int n;

    always #4 sys_clk = ~sys_clk;

    tm_timer_io tm_timer_io_inst (
        .sys_clk(sys_clk), .rst_b(rst_b), .wb_req(req), .wb_dat_o(rdat),
        .wb_ack_o(ack), .port5_in(p_in), .port5_out(p_out), .port5_oe(p_oe),
        .counter_done_request(done), .input_edge_request(in_edge)
    );
    tm_pin_model tm_pin_model_inst (
        .port5_out(p_out), .port5_oe(p_oe), .event_level(ev), .port5_in(p_in)
    );

    // Pulse tallies on the falling edge, clear of the launching edge.
    always @(negedge sys_clk) begin
        if (done === 1'b1) n_done++;
        if (in_edge === 1'b1) n_edge++;
    end

    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task miss(input string s);
        bad_count++;
        $display("MISMATCH at %0t: %s", $time, s);
    endtask
    task chk8(input logic [7:0] g, input logic [7:0] e, input string s);
        total_checks++;
        if (g !== e) miss(s);
    endtask
    task chk_b(input logic g, input logic e, input string s);
        total_checks++;
        if (g !== e) miss(s);
    endtask
    task chk_n(input int g, input int lo, input int hi, input string s);
        total_checks++;
        if (g < lo || g > hi) miss(s);
    endtask
    task ticks(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    // One classic cycle, held until ack is sampled, released at that edge.
    task bus(input logic w, input logic [7:0] i, input logic [7:0] d);
        int k;
        @(posedge sys_clk);
        req <= '{1'b1, 1'b1, w, 4'hF, {i, 2'h0}, {24'h0, d}};
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (ack !== 1'b1 && k < 40);
        if (k >= 40) begin
            miss("no ack");
            give_verdict;
        end
        r = rdat[7:0];
        req <= '0;
    endtask
    task wait_done(input int lim);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (done !== 1'b1 && n < lim);
        if (n >= lim) begin
            miss("no end-of-count");
            give_verdict;
        end
    endtask
    task fall;
        @(posedge sys_clk);
        ev <= 1'b0;
        ticks(8);
        ev <= 1'b1;
        ticks(8);
    endtask
    task no_done(input int k, input string s);
        int d;
        d = n_done;
        ticks(k);
        chk_n(n_done - d, 0, 0, s);
    endtask

    // Reset values; with every line an input the port reads the pull-ups.
    task s_reset;
        logic [7:0] ix[5];
        logic [7:0] ex[5];
        ix = '{TM_IDX_P5_DATA, TM_IDX_P5_DIR, TM_IDX_MODE, TM_IDX_COUNT, TM_IDX_SCALER};
        ex = '{8'hFF, TM_P5_DIR_RST, TM_MODE_RST, TM_COUNT_RST, TM_SCALER_RST};
        for (int j = 0; j < 5; j++) begin
            bus(1'b0, ix[j], 8'h00);
            chk8(r, ex[j], "reset value");
        end
        chk8(p_oe, 8'h00, "reset enables");
        bus(1'b1, 8'h33, 8'h5A);
        bus(1'b0, 8'h33, 8'h00);
        chk8(r, 8'h00, "unmapped read");
    endtask
    // Toggle output: exact period, inversion, port lock, load forcing high.
    task s_toggle;
        logic a;
        logic b;
        bus(1'b1, TM_IDX_P5_DIR, 8'hBF);
        bus(1'b1, TM_IDX_SCALER, 8'h07);
        bus(1'b1, TM_IDX_COUNT, 8'h04);
        bus(1'b1, TM_IDX_MODE, 8'h8C);
        wait_done(100);
        ticks(3);
        a = p_out[TM_LINE_OUT];
        wait_done(100);
        chk_n(n, 4 * TK - 3, 4 * TK - 3, "toggle period");
        ticks(3);
        b = p_out[TM_LINE_OUT];
        chk_b(b, ~a, "no toggle");
        bus(1'b1, TM_IDX_P5_DATA, {8{~b}});
        ticks(3);
        chk_b(p_out[TM_LINE_OUT], b, "port write reached line");
        bus(1'b0, TM_IDX_P5_DATA, 8'h00);
        chk_b(r[TM_LINE_OUT], b, "port read of line");
        if (b === 1'b1) wait_done(100);
        ticks(3);
        bus(1'b1, TM_IDX_MODE, 8'h8C);
        ticks(3);
        chk_b(p_out[TM_LINE_OUT], 1'b1, "load did not set output");
        ticks(2);
        bus(1'b0, TM_IDX_MODE, 8'h00);
        chk8(r, 8'h88, "load bit kept");
    endtask
    // Internal clock on the line, then plain port data.
    task s_iclk;
        logic a;
        bus(1'b1, TM_IDX_MODE, 8'hC0);
        ticks(4);
        a = p_out[TM_LINE_OUT];
        ticks(1);
        chk_b(p_out[TM_LINE_OUT], ~a, "internal clock");
        bus(1'b1, TM_IDX_MODE, 8'h00);
        bus(1'b1, TM_IDX_P5_DATA, 8'h40);
        ticks(3);
        chk_b(p_out[TM_LINE_OUT], 1'b1, "port data high");
        bus(1'b1, TM_IDX_P5_DATA, 8'h00);
        ticks(3);
        chk_b(p_out[TM_LINE_OUT], 1'b0, "port data low");
    endtask
    // External events: the third falling edge ends a count of three.
    task s_ext;
        int d;
        int e;
        bus(1'b1, TM_IDX_SCALER, 8'h05);
        bus(1'b1, TM_IDX_COUNT, 8'h03);
        bus(1'b1, TM_IDX_MODE, 8'h0C);
        d = n_done;
        e = n_edge;
        fall;
        fall;
        chk_n(n_done - d, 0, 0, "early count");
        fall;
        ticks(10);
        chk_n(n_done - d, 1, 1, "events not counted");
        chk_n(n_edge - e, 3, 3, "edge requests");
    endtask
    // Gate low holds the count; gate high lets two ticks through.
    task s_gate;
        bus(1'b1, TM_IDX_COUNT, 8'h02);
        ev <= 1'b0;
        bus(1'b1, TM_IDX_MODE, 8'h1C);
        no_done(80, "counted with gate low");
        ev <= 1'b1;
        wait_done(80);
        chk_n(n, TK, 2 * TK + 14, "gated interval");
        bus(1'b1, TM_IDX_MODE, 8'h00);
    endtask
    // Two edges 24 cycles apart in single pass; the interval is measured
    // from the first, then enable must be clear and edges ignored.
    task s_two(input logic [7:0] mode, input int lo, input int hi);
        int k;
        bus(1'b1, TM_IDX_MODE, mode);
        no_done(100, "started without edge");
        k = 0;
        ev <= 1'b0;
        while (done !== 1'b1 && k < 300) begin
            @(posedge sys_clk);
            k++;
            if (k == 12 || k == 36) ev <= 1'b1;
            if (k == 24) ev <= 1'b0;
        end
        chk_n(k, lo, hi, "trigger interval");
        ticks(4);
        bus(1'b0, TM_IDX_MODE, 8'h00);
        chk8(r & 8'h08, 8'h00, "enable not cleared");
        fall;
        no_done(120, "edge ignored wrongly");
    endtask

    initial begin
        sys_clk = 1'b0;
        rst_b = 1'b0;
        ev = 1'b1;
        req = '0;
        bad_count = 0;
        total_checks = 0;
        n_done = 0;
        n_edge = 0;
        ticks(5);
        rst_b <= 1'b1;
        s_reset;
        s_toggle;
        s_iclk;
        s_ext;
        s_gate;
        bus(1'b1, TM_IDX_SCALER, 8'h04);
        bus(1'b1, TM_IDX_COUNT, 8'h08);
        s_two(8'h28, 8 * TK - 3, 8 * TK + 4);
        s_two(8'h38, 8 * TK + 21, 8 * TK + 28);
        give_verdict;
    end
endmodule
